// ==== include/cfef_pkg.sv ====
// Constants shared by the codec fault and event flag block
package cfef_pkg;

  // Register numbers on the control bus
  localparam int              REG_AW          = 7;
  localparam logic [6:0]      REG_DRV_STATUS  = 7'h5f;  // driver_fault_status
  localparam logic [6:0]      REG_LATCHED     = 7'h60;  // latched_event_flags
  localparam logic [6:0]      REG_LIVE        = 7'h61;  // live_event_flags
  localparam logic [6:0]      REG_BTN_CLEAR   = 7'h0e;  // Read of this register clears live button bit

  // Bit positions used in the three registers
  localparam int              BIT_SHORT_L     = 7;
  localparam int              BIT_SHORT_R     = 6;
  localparam int              BIT_SHORT_COM   = 5;
  localparam int              BIT_COM_POWER   = 3;
  localparam int              BIT_BUTTON      = 3;
  localparam int              BIT_HEADSET     = 2;
  localparam int              BIT_NOISE_L     = 1;
  localparam int              BIT_NOISE_R     = 0;

  // Values after reset, and the data returned for unmapped reads
  localparam logic [7:0]      FLAGS_RST       = 8'h00;
  localparam logic [7:0]      RD_DATA_RST     = 8'h00;
  localparam logic [7:0]      UNMAPPED_DATA   = 8'h00;

  // Interrupt pulse timing
  localparam int              CLK_PERIOD_NS   = 25;
  localparam int              IRQ_PULSE_NS    = 2000000;
  localparam int              IRQ_CNT_W       = 17;
  localparam logic [16:0]     IRQ_PULSE_CYC_DEF = 17'(IRQ_PULSE_NS / CLK_PERIOD_NS);
  localparam logic [16:0]     IRQ_CNT_RST     = 17'h00000;

  // Interrupt pulse generator states
  typedef enum logic [1:0] {
    IRQ_IDLE,
    IRQ_ON,
    IRQ_OFF
  } cfef_irq_state_t;

endpackage : cfef_pkg

// ==== logic/cfef_flag_reg.sv ====
// Sticky flag register where a set always beats a clear
`timescale 1ns/1ps
module cfef_flag_reg
  import cfef_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,  // System clock
  input  wire logic         nrst_i,     // Synchronous reset, active low
  input  wire logic [W-1:0] set_i,      // Per-bit set request
  input  wire logic [W-1:0] clr_i,      // Per-bit clear request
  output logic      [W-1:0] flags_o     // Held flags
);

  logic [W-1:0] flags_r;    // Flag storage
  logic [W-1:0] flags_nxt;  // Next flag value

  // Keep, clear, then set so an arriving event is never lost
  always_comb begin
    flags_nxt = (flags_r & ~clr_i) | set_i;
  end

  // Register the flags
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      flags_r <= W'(FLAGS_RST);
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

endmodule : cfef_flag_reg

// ==== logic/cfef_top.sv ====
// Fault status and event flag registers with interrupt pulse output
`timescale 1ns/1ps
module cfef_top
  import cfef_pkg::*;
#(
  parameter logic [16:0] IRQ_PULSE_CYC = IRQ_PULSE_CYC_DEF  // Interrupt pulse length in clocks
) (
  input  wire logic              ref_clk_i,             // System clock, 40 MHz
  input  wire logic              nrst_i,                // Synchronous reset, active low
  input  wire logic              rd_en_i,               // Register read strobe
  input  wire logic [REG_AW-1:0] rd_addr_i,             // Register number being read
  output logic      [7:0]        rd_data_o,             // Read data, one cycle after strobe
  output logic                   rd_valid_o,            // Read data valid pulse
  input  wire logic              short_left_i,          // Short on left_headphone_driver
  input  wire logic              short_right_i,         // Short on right_headphone_driver
  input  wire logic              short_common_i,        // Short on headphone_common_driver
  input  wire logic              common_powered_i,      // headphone_common_driver fully up
  input  wire logic              button_press_i,        // Headset button pressed
  input  wire logic              headset_present_i,     // Headset detected
  input  wire logic              noise_left_i,          // Left record power under noise threshold
  input  wire logic              noise_right_i,         // Right record power under noise threshold
  input  wire logic              irq_continuous_i,      // Continuous interrupt pulsing selected
  output logic                   irq_o                  // Interrupt output, active high
);

  // Address match, used by several decodes
  function automatic logic reg_hit(input logic [REG_AW-1:0] addr, input logic [REG_AW-1:0] num);
    reg_hit = (addr == num);
  endfunction : reg_hit

  // Read decodes
  logic rd_status;   // Read of driver_fault_status
  logic rd_latched;  // Read of latched_event_flags
  logic rd_live;     // Read of live_event_flags
  logic rd_btn_clr;  // Read that clears the live button bit

  assign rd_status  = rd_en_i && reg_hit(rd_addr_i, REG_DRV_STATUS);
  assign rd_latched = rd_en_i && reg_hit(rd_addr_i, REG_LATCHED);
  assign rd_live    = rd_en_i && reg_hit(rd_addr_i, REG_LIVE);
  assign rd_btn_clr = rd_en_i && reg_hit(rd_addr_i, REG_BTN_CLEAR);

  // Headset presence edge tracking
  logic headset_prev_r;   // Presence seen last cycle
  logic headset_prev_nxt; // Next presence history
  logic headset_change;   // Insertion or removal this cycle

  // Track presence to see changes in either direction
  always_comb begin
    headset_prev_nxt = headset_present_i;
  end

  // Register presence history
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      headset_prev_r <= 1'b0;
    end else begin
      headset_prev_r <= headset_prev_nxt;
    end
  end

  assign headset_change = headset_present_i ^ headset_prev_r;

  // Event vector for the latched flags
  logic [7:0] shorts_w;     // Short bits placed at their positions
  logic [7:0] event_set;    // Conditions that set latched flags
  logic [7:0] event_clr;    // Clear request from a flags read
  logic [7:0] latched_q;    // Latched flag contents
  logic [0:0] btn_live_q;   // Sticky button bit of the live register
  logic       irq_trigger;  // A new flag is about to latch

  // Gather the shorts once, reused by three registers
  always_comb begin
    shorts_w                = 8'h00;
    shorts_w[BIT_SHORT_L]   = short_left_i;
    shorts_w[BIT_SHORT_R]   = short_right_i;
    shorts_w[BIT_SHORT_COM] = short_common_i;
  end

  // Build set and clear vectors for the latched flags
  always_comb begin
    event_set              = shorts_w;
    event_set[BIT_BUTTON]  = button_press_i;
    event_set[BIT_HEADSET] = headset_change;
    event_set[BIT_NOISE_L] = noise_left_i;
    event_set[BIT_NOISE_R] = noise_right_i;
    // Read clears bits whose cause has gone; live causes set again
    event_clr = rd_latched ? ~event_set : 8'h00;
  end

  // Latched event flags; set beats clear so nothing is lost
  cfef_flag_reg #(
    .W         (8)
  ) u_latched (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .set_i     (event_set),
    .clr_i     (event_clr),
    .flags_o   (latched_q)
  );

  // Live button bit behaves as sticky, cleared by its own read
  cfef_flag_reg #(
    .W         (1)
  ) u_btn_live (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .set_i     (button_press_i),
    .clr_i     (rd_btn_clr),
    .flags_o   (btn_live_q)
  );

  // Interrupt fires when a condition sets a flag not yet held
  assign irq_trigger = |(event_set & ~latched_q);

  // Register read images
  logic [7:0] status_img;  // driver_fault_status contents
  logic [7:0] live_img;    // live_event_flags contents

  // Compose the status and live images
  always_comb begin
    status_img                = shorts_w;
    status_img[BIT_COM_POWER] = common_powered_i;
    live_img                  = shorts_w;
    live_img[BIT_BUTTON]      = btn_live_q[0];
    live_img[BIT_HEADSET]     = headset_present_i;
    live_img[BIT_NOISE_L]     = noise_left_i;
    live_img[BIT_NOISE_R]     = noise_right_i;
  end

  // Read port
  logic [7:0] rd_data_r;    // Read data register
  logic [7:0] rd_data_nxt;  // Next read data
  logic       rd_valid_r;   // Read valid register
  logic       rd_valid_nxt; // Next read valid

  // Select read data; writes do not exist, reserved bits are zero
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = rd_en_i;
    if (rd_en_i) begin
      if (rd_status) begin
        rd_data_nxt = status_img;
      end else if (rd_latched) begin
        rd_data_nxt = latched_q;
      end else if (rd_live) begin
        rd_data_nxt = live_img;
      end else begin
        rd_data_nxt = UNMAPPED_DATA;  // Other registers live elsewhere
      end
    end
  end

  // Register read data and valid
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rd_data_r  <= RD_DATA_RST;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data_o  = rd_data_r;
  assign rd_valid_o = rd_valid_r;

  // Interrupt pulse generator
  cfef_irq_state_t        irq_state_r;   // Pulse state
  cfef_irq_state_t        irq_state_nxt; // Next pulse state
  logic [IRQ_CNT_W-1:0]   irq_cnt_r;     // Cycles spent in current phase
  logic [IRQ_CNT_W-1:0]   irq_cnt_nxt;   // Next phase count
  logic                   irq_r;         // Interrupt output register
  logic                   irq_nxt;       // Next interrupt level
  logic                   phase_done;    // Current phase has run its length

  assign phase_done = (irq_cnt_r == IRQ_PULSE_CYC - 17'h00001);

  // Single mode gives one pulse; continuous repeats on/off until a flags read
  always_comb begin
    irq_state_nxt = irq_state_r;
    irq_cnt_nxt   = irq_cnt_r + 17'h00001;
    unique case (irq_state_r)
      IRQ_IDLE: begin
        irq_cnt_nxt = IRQ_CNT_RST;
        if (irq_trigger) begin
          irq_state_nxt = IRQ_ON;
        end
      end
      IRQ_ON: begin
        if (irq_continuous_i && rd_latched && !irq_trigger) begin
          irq_state_nxt = IRQ_IDLE;
          irq_cnt_nxt   = IRQ_CNT_RST;
        end else if (phase_done) begin
          irq_state_nxt = irq_continuous_i ? IRQ_OFF : IRQ_IDLE;
          irq_cnt_nxt   = IRQ_CNT_RST;
        end
      end
      IRQ_OFF: begin
        if (!irq_continuous_i || (rd_latched && !irq_trigger)) begin
          irq_state_nxt = IRQ_IDLE;
          irq_cnt_nxt   = IRQ_CNT_RST;
        end else if (phase_done) begin
          irq_state_nxt = IRQ_ON;
          irq_cnt_nxt   = IRQ_CNT_RST;
        end
      end
    endcase
    irq_nxt = (irq_state_nxt == IRQ_ON);
  end

  // Register pulse state, count and output
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      irq_state_r <= IRQ_IDLE;
      irq_cnt_r   <= IRQ_CNT_RST;
      irq_r       <= 1'b0;
    end else begin
      irq_state_r <= irq_state_nxt;
      irq_cnt_r   <= irq_cnt_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign irq_o = irq_r;

  // Checks on the registers and the interrupt
  a_status_shorts: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_status |=> rd_data_o[7:5] == $past(shorts_w[7:5]))
    else $error("Status shorts not reported live");

  a_status_power: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_status |=> rd_data_o[BIT_COM_POWER] == $past(common_powered_i))
    else $error("Common driver power bit wrong");

  a_status_reserved: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_status |=> rd_valid_o && rd_data_o[4] == 1'b0 && rd_data_o[2:0] == 3'h0)
    else $error("Reserved status bits not zero");

  a_sticky_hold: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    latched_q[BIT_SHORT_L] && !rd_latched |=> latched_q[BIT_SHORT_L])
    else $error("Latched flag dropped without a read");

  a_short_latch: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    short_right_i ##1 (rd_en_i && rd_addr_i == REG_LATCHED) |=> rd_data_o[BIT_SHORT_R])
    else $error("Right short not latched");

  a_button_latch: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    button_press_i |=> latched_q[BIT_BUTTON])
    else $error("Button press not latched");

  a_headset_change: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $changed(headset_present_i) |=> latched_q[BIT_HEADSET])
    else $error("Headset change not latched");

  a_noise_latch: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (noise_left_i && noise_right_i) |=> latched_q[1:0] == 2'b11)
    else $error("Noise gate not latched");

  a_live_shorts: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_live |=> rd_data_o[7:5] == $past(shorts_w[7:5]) && rd_data_o[4] == 1'b0)
    else $error("Live shorts wrong");

  a_live_headset: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_live |=> rd_data_o[BIT_HEADSET] == $past(headset_present_i))
    else $error("Live headset bit wrong");

  a_live_noise: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_live && !noise_left_i && !noise_right_i |=> rd_data_o[1:0] == 2'b00)
    else $error("Live noise bits wrong");

  a_button_sticky: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    btn_live_q[0] && !button_press_i && rd_btn_clr |=> !btn_live_q[0])
    else $error("Live button bit not cleared by read");

  a_irq_stop: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    irq_continuous_i && rd_latched && !irq_trigger |=> !irq_o && irq_state_r == IRQ_IDLE)
    else $error("Continuous interrupt kept pulsing after flags read");

  a_clear_read: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_latched && !noise_right_i |=> !latched_q[BIT_NOISE_R] && rd_data_o == $past(latched_q))
    else $error("Flags read did not return then clear");

endmodule : cfef_top

// ==== tb/cfef_host_model.sv ====
// Host processor model that reads the flag registers over the read port
`timescale 1ns/1ps
module cfef_host_model
  import cfef_pkg::*;
(
  input  wire logic              ref_clk_i,   // System clock
  input  wire logic              rd_valid_i,  // Read answer strobe
  input  wire logic [7:0]        rd_data_i,   // Read answer data
  output logic                   rd_en_o,     // Read strobe
  output logic [REG_AW-1:0]      rd_addr_o    // Register number
);
  // Idle bus at time zero
  initial begin
    rd_en_o   = 1'b0;
    rd_addr_o = 7'h00;
  end

  // One read: strobe for one edge, take the answer one cycle later
  // The port has no write path, so reserved bits are never written
  task automatic read_reg(input logic [REG_AW-1:0] a, output logic [7:0] d, output logic v);
    rd_en_o   = 1'b1;
    rd_addr_o = a;
    @(posedge ref_clk_i);
    #1;
    v         = rd_valid_i;
    d         = rd_data_i;
    rd_en_o   = 1'b0;
    rd_addr_o = ~a;          // Released address shows a changed value
    @(posedge ref_clk_i);
    #1;
  endtask : read_reg
endmodule : cfef_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the fault status and event flag block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top
  import cfef_pkg::*;
;
  localparam logic [16:0] PULSE = 17'h00008;  // Short interrupt pulse for sim
  logic              ref_clk = 1'b0;          // Clock, 25 ns period
  logic              nrst = 1'b0;             // Reset, active low
  logic              rd_en;                   // Read strobe from host
  logic [REG_AW-1:0] rd_addr;                 // Read number from host
  logic [7:0]        rd_data;                 // Read data
  logic              rd_valid;                // Read valid
  logic              sl = 1'b0, sr = 1'b0, sc = 1'b0, cp = 1'b0;  // Shorts and power
  logic              bp = 1'b0, hp = 1'b0, nl = 1'b0, nr = 1'b0;  // Events
  logic              ic = 1'b0;               // Continuous interrupt select
  logic              irq;                     // Interrupt output
  int                mismatches = 0;          // Failed comparisons
  int                checks = 0;              // All comparisons
  int                cyc_cnt = 0;             // Cycles since start

  always #12.5 ref_clk = ~ref_clk;

  cfef_host_model host (.ref_clk_i(ref_clk), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
                        .rd_en_o(rd_en), .rd_addr_o(rd_addr));

  cfef_top #(.IRQ_PULSE_CYC(PULSE)) dut (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .short_left_i(sl), .short_right_i(sr),
    .short_common_i(sc), .common_powered_i(cp), .button_press_i(bp),
    .headset_present_i(hp), .noise_left_i(nl), .noise_right_i(nr),
    .irq_continuous_i(ic), .irq_o(irq));

  // Verdict and end of run
  task automatic stop_test();
    if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Hang guard: the tests need well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  // Let n edges pass, then sit just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Read a register and compare data and valid strobe
  task automatic rchk(input logic [REG_AW-1:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    logic       v;
    host.read_reg(a, d, v);
    `CHK(nm, e, d)
    `CHK("rd_valid", 1'b1, v)
  endtask : rchk

  // Idle values of the three flag registers, an unmapped number too
  task automatic s_reset();
    rchk(REG_DRV_STATUS, 8'h00, "status idle");
    rchk(REG_LATCHED, 8'h00, "latched idle");
    rchk(REG_LIVE, 8'h00, "live idle");
    rchk(7'h10, UNMAPPED_DATA, "unmapped");
  endtask : s_reset

  // Live shorts and power, then latched shorts after they end
  task automatic s_status();
    sl = 1'b1; sr = 1'b1; sc = 1'b1; cp = 1'b1;
    cyc(1);
    rchk(REG_DRV_STATUS, 8'he8, "status all");
    rchk(REG_LIVE, 8'he0, "live shorts");
    sr = 1'b0; sc = 1'b0; cp = 1'b0;
    cyc(1);
    rchk(REG_DRV_STATUS, 8'h80, "status left");
    sl = 1'b0;
    cyc(1);
    rchk(REG_LATCHED, 8'he0, "latched shorts");
    rchk(REG_LATCHED, 8'h00, "latched clear");
  endtask : s_status

  // Button bit: sticky in both registers, live cleared by register 14
  task automatic s_button();
    bp = 1'b1;
    cyc(1);
    bp = 1'b0;
    cyc(2);
    rchk(REG_LIVE, 8'h08, "live button");
    rchk(REG_LATCHED, 8'h08, "latched button");
    rchk(REG_LATCHED, 8'h00, "button cleared");
    rchk(REG_LIVE, 8'h08, "live button held");
    rchk(REG_BTN_CLEAR, 8'h00, "clear read");
    rchk(REG_LIVE, 8'h00, "live button gone");
  endtask : s_button

  // Headset change latches both ways, live shows presence
  task automatic s_headset();
    hp = 1'b1;
    cyc(1);
    rchk(REG_LIVE, 8'h04, "live headset");
    rchk(REG_LATCHED, 8'h04, "insert");
    rchk(REG_LATCHED, 8'h00, "insert cleared");
    hp = 1'b0;
    cyc(1);
    rchk(REG_LATCHED, 8'h04, "removal");
    rchk(REG_LIVE, 8'h00, "live no headset");
  endtask : s_headset

  // Noise gate: an active cause keeps its latched bit through a read
  task automatic s_noise();
    nl = 1'b1; nr = 1'b1;
    cyc(1);
    rchk(REG_LIVE, 8'h03, "live noise");
    rchk(REG_LATCHED, 8'h03, "latched noise");
    rchk(REG_LATCHED, 8'h03, "noise kept");
    nl = 1'b0; nr = 1'b0;
    cyc(1);
    rchk(REG_LATCHED, 8'h03, "noise sticky");
    rchk(REG_LATCHED, 8'h00, "noise cleared");
  endtask : s_noise

  // Single pulse lasts exactly the pulse length
  task automatic s_irq_single();
    cyc(20);
    sl = 1'b1;
    cyc(1);
    sl = 1'b0;
    `CHK("irq rise", 1'b1, irq)
    cyc(7);
    `CHK("irq last", 1'b1, irq)
    cyc(1);
    `CHK("irq end", 1'b0, irq)
    rchk(REG_LATCHED, 8'h80, "irq cause");
  endtask : s_irq_single

  // Continuous pulses repeat until the latched flags are read
  task automatic s_irq_cont();
    cyc(20);
    ic = 1'b1;
    sc = 1'b1;
    cyc(1);
    sc = 1'b0;
    `CHK("cont on", 1'b1, irq)
    cyc(8);
    `CHK("cont off", 1'b0, irq)
    cyc(7);
    `CHK("cont off end", 1'b0, irq)
    cyc(1);
    `CHK("cont again", 1'b1, irq)
    rchk(REG_LATCHED, 8'h20, "cont cause");
    for (int i = 0; i < 20; i++) begin
      `CHK("cont stopped", 1'b0, irq)
      cyc(1);
    end
    ic = 1'b0;
  endtask : s_irq_cont

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    s_reset();
    s_status();
    s_button();
    s_headset();
    s_noise();
    s_irq_single();
    s_irq_cont();
    stop_test();
  end
endmodule : tb_top
